// ### src/adc_config_register_bank.sv
// configuration register bank with AXI4-Lite slave and analog control outputs
// Operation
// - modulator clock divides oscillator by 128 or 256
// - reference powered only while enable bit set
// - level bit picks 1.25V or 2.5V reference
// - input buffer enabled by config bit 1
// - config bit 0 sets output bit order
// - incoming bytes always most significant bit first
// - multi-byte output always most significant byte first
// - top three config bits read fixed factory code
// - burnout sources follow analog control bit 7
// - second current source range, 00 off
// - first current source range, 00 off
// - gain field selects power of two gain
// - first current source code sets output linearly
// - second current source code sets output linearly
// - direction bit 0 output, 1 input
// - all digital pins inputs after power-up
// - level register drives outputs, reads input pins
//
// Register access over AXI4-Lite was chosen for this implementation.
module adc_config_register_bank
   import adc_cfg_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [adc_cfg_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [adc_cfg_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic modClockEn,
   output logic vrefEnable,
   output logic internalVrefLevel,
   output logic bufferEnable,
   output logic lsbFirstOut,
   output logic [3:0] positiveInputPick,
   output logic [3:0] negativeInputPick,
   output logic positiveIsCommon,
   output logic negativeIsCommon,
   output logic positiveIsTemp,
   output logic negativeIsTemp,
   output logic burnoutSourceOn,
   output logic [1:0] currentSourceOneRange,
   output logic [1:0] currentSourceTwoRange,
   output logic [7:0] currentSourceOneCode,
   output logic [7:0] currentSourceTwoCode,
   output logic [2:0] gainSelect,
   output logic [7:0] gainFactor,
   output logic offsetNegative,
   output logic [6:0] offsetMagnitude,
   input wire logic [7:0] gpioIn,
   output logic [7:0] gpioOut,
   output logic [7:0] gpioOe
);
   import adc_cfg_pkg::*;

   logic [4:0] configMain_q;
   logic [7:0] inputSelector_q;
   logic [7:0] analogControl_q;
   logic [7:0] curOneCode_q;
   logic [7:0] curTwoCode_q;
   logic [7:0] offsetTrim_q;
   logic [7:0] gpioLevel_q;
   logic [7:0] gpioWay_q;
   logic [7:0] gpioSync1_q;
   logic [7:0] gpioSync2_q;
   logic [7:0] modCount_q;
   logic modEn_q;

   // write channel holding
   logic awHeld_q;
   logic wHeld_q;
   logic [ADDR_W-1:0] awAddr_q;
   logic [7:0] wByte_q;
   logic wLane_q;
   logic bValid_q;
   logic [1:0] bResp_q;
   logic rValid_q;
   logic [31:0] rData_q;
   logic [1:0] rResp_q;

   wire awTake = s_axi_awvalid && s_axi_awready;
   wire wTake = s_axi_wvalid && s_axi_wready;
   wire arTake = s_axi_arvalid && s_axi_arready;
   wire haveAw = awHeld_q || awTake;
   wire haveW = wHeld_q || wTake;
   wire doWrite = haveAw && haveW && !bValid_q;
   wire [ADDR_W-1:0] wrAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
   wire [7:0] wrByte = wHeld_q ? wByte_q : s_axi_wdata[7:0];
   wire wrLane = wHeld_q ? wLane_q : s_axi_wstrb[0];
   // write address hits
   wire wrHitCfg = (wrAddr == CONFIG_MAIN_OFF);
   wire wrHitSel = (wrAddr == INPUT_SELECTOR_OFF);
   wire wrHitAna = (wrAddr == ANALOG_CONTROL_OFF);
   wire wrHitOne = (wrAddr == CUR_ONE_CODE_OFF);
   wire wrHitTwo = (wrAddr == CUR_TWO_CODE_OFF);
   wire wrHitOff = (wrAddr == OFFSET_TRIM_OFF);
   wire wrHitLvl = (wrAddr == GPIO_LEVEL_OFF);
   wire wrHitWay = (wrAddr == GPIO_WAY_OFF);
   wire wrMapped = |{wrHitCfg, wrHitSel, wrHitAna, wrHitOne, wrHitTwo, wrHitOff, wrHitLvl, wrHitWay};
   wire wrEn = doWrite && wrMapped && wrLane;

   // per-register write strobes
   wire wrCfg = wrEn && wrHitCfg;
   wire wrSel = wrEn && wrHitSel;
   wire wrAna = wrEn && wrHitAna;
   wire wrOne = wrEn && wrHitOne;
   wire wrTwo = wrEn && wrHitTwo;
   wire wrOff = wrEn && wrHitOff;
   wire wrLvl = wrEn && wrHitLvl;
   wire wrWay = wrEn && wrHitWay;

   assign s_axi_awready = !awHeld_q && !bValid_q;
   assign s_axi_wready = !wHeld_q && !bValid_q;
   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;
   assign s_axi_arready = !rValid_q;
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rdata = rData_q;
   assign s_axi_rresp = rResp_q;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= '0;
         wByte_q <= 8'h00;
         wLane_q <= 1'b0;
      end else begin
         if (awTake && !doWrite) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end else if (doWrite) begin
            awHeld_q <= 1'b0;
         end
         if (wTake && !doWrite) begin
            wHeld_q <= 1'b1;
            wByte_q <= s_axi_wdata[7:0];
            wLane_q <= s_axi_wstrb[0];
         end else if (doWrite) begin
            wHeld_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bValid_q <= 1'b0;
         bResp_q <= RESP_OKAY;
      end else if (doWrite) begin
         bValid_q <= 1'b1;
         bResp_q <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bValid_q <= 1'b0;
      end
   end

   // register storage; factory bits are not stored
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         configMain_q <= CONFIG_MAIN_RST;
      end else if (wrCfg) begin
         configMain_q <= wrByte[4:0];
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         inputSelector_q <= INPUT_SELECTOR_RST;
      end else if (wrSel) begin
         inputSelector_q <= wrByte;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         analogControl_q <= ANALOG_CONTROL_RST;
      end else if (wrAna) begin
         analogControl_q <= wrByte;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         curOneCode_q <= CUR_CODE_RST;
      end else if (wrOne) begin
         curOneCode_q <= wrByte;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         curTwoCode_q <= CUR_CODE_RST;
      end else if (wrTwo) begin
         curTwoCode_q <= wrByte;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         offsetTrim_q <= OFFSET_TRIM_RST;
      end else if (wrOff) begin
         offsetTrim_q <= wrByte;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         gpioLevel_q <= GPIO_LEVEL_RST;
      end else if (wrLvl) begin
         gpioLevel_q <= wrByte;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         gpioWay_q <= GPIO_WAY_RST;
      end else if (wrWay) begin
         gpioWay_q <= wrByte;
      end
   end

   // pin inputs through two flops
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         gpioSync1_q <= 8'h00;
         gpioSync2_q <= 8'h00;
      end else begin
         gpioSync1_q <= gpioIn;
         gpioSync2_q <= gpioSync1_q;
      end
   end

   // per pin: output level from register, input level from pin
   logic [7:0] gpioReadBack;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : gpioBit
         assign gpioReadBack[gi] = gpioWay_q[gi] ? gpioSync2_q[gi] : gpioLevel_q[gi];
         assign gpioOe[gi] = !gpioWay_q[gi];
      end
   endgenerate
   assign gpioOut = gpioLevel_q;

   // read decode
   wire rdHitCfg = (s_axi_araddr == CONFIG_MAIN_OFF);
   wire rdHitSel = (s_axi_araddr == INPUT_SELECTOR_OFF);
   wire rdHitAna = (s_axi_araddr == ANALOG_CONTROL_OFF);
   wire rdHitOne = (s_axi_araddr == CUR_ONE_CODE_OFF);
   wire rdHitTwo = (s_axi_araddr == CUR_TWO_CODE_OFF);
   wire rdHitOff = (s_axi_araddr == OFFSET_TRIM_OFF);
   wire rdHitLvl = (s_axi_araddr == GPIO_LEVEL_OFF);
   wire rdHitWay = (s_axi_araddr == GPIO_WAY_OFF);

   wire rdMapped = |{rdHitCfg, rdHitSel, rdHitAna, rdHitOne, rdHitTwo, rdHitOff, rdHitLvl, rdHitWay};
   logic [7:0] rdByte;
   always_comb begin
      rdByte = 8'h00;
      unique case (s_axi_araddr)
         CONFIG_MAIN_OFF: rdByte = {FACTORY_CODE, configMain_q};
         INPUT_SELECTOR_OFF: rdByte = inputSelector_q;
         ANALOG_CONTROL_OFF: rdByte = analogControl_q;
         CUR_ONE_CODE_OFF: rdByte = curOneCode_q;
         CUR_TWO_CODE_OFF: rdByte = curTwoCode_q;
         OFFSET_TRIM_OFF: rdByte = offsetTrim_q;
         GPIO_LEVEL_OFF: rdByte = gpioReadBack;
         GPIO_WAY_OFF: rdByte = gpioWay_q;
         default: rdByte = 8'h00;
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rValid_q <= 1'b0;
         rData_q <= 32'h0;
         rResp_q <= RESP_OKAY;
      end else if (arTake) begin
         rValid_q <= 1'b1;
         rData_q <= {24'h0, rdByte};
         rResp_q <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rValid_q <= 1'b0;
      end
   end

   // modulator clock enable from the oscillator clock
   wire speedSlow = configMain_q[SPEED_BIT];
   wire [7:0] modLast = speedSlow ? 8'(MOD_DIV_SLOW - 1) : 8'(MOD_DIV_FAST - 1);
   wire modWrap = (modCount_q >= modLast);
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         modCount_q <= 8'h00;
         modEn_q <= 1'b0;
      end else begin
         modEn_q <= modWrap;
         modCount_q <= modWrap ? 8'h00 : modCount_q + 8'h01;
      end
   end
   assign modClockEn = modEn_q;

   assign vrefEnable = configMain_q[VREF_EN_BIT];
   assign internalVrefLevel = configMain_q[VREF_LEVEL_BIT];
   assign bufferEnable = configMain_q[BUF_EN_BIT];
   // affects only serial output bit order within a byte; input and byte order fixed
   // serial side keeps input msb first and bytes msb first
   assign lsbFirstOut = configMain_q[BIT_ORDER_BIT];

   assign positiveInputPick = inputSelector_q[7:4];
   assign negativeInputPick = inputSelector_q[3:0];
   assign positiveIsTemp = &inputSelector_q[7:4];
   assign negativeIsTemp = &inputSelector_q[3:0];
   assign positiveIsCommon = inputSelector_q[7] && !positiveIsTemp;
   assign negativeIsCommon = inputSelector_q[3] && !negativeIsTemp;

   assign burnoutSourceOn = analogControl_q[BURNOUT_BIT];
   assign currentSourceTwoRange = analogControl_q[RANGE_TWO_LSB +: 2];
   assign currentSourceOneRange = analogControl_q[RANGE_ONE_LSB +: 2];
   assign gainSelect = analogControl_q[GAIN_LSB +: 3];
   assign gainFactor = 8'h01 << gainSelect;

   // code reaches the dac only while its range is not off
   assign currentSourceOneCode = (currentSourceOneRange == 2'h0) ? 8'h00 : curOneCode_q;
   assign currentSourceTwoCode = (currentSourceTwoRange == 2'h0) ? 8'h00 : curTwoCode_q;

   assign offsetNegative = offsetTrim_q[SIGN_BIT];
   assign offsetMagnitude = offsetTrim_q[6:0];
endmodule // adc_config_register_bank

// ### src/adc_cfg_pkg.sv
// package: register map, field positions, reset values for the converter configuration bank
package adc_cfg_pkg;
   localparam logic [7:0] CONFIG_MAIN_OFF = 8'h00;
   localparam logic [7:0] INPUT_SELECTOR_OFF = 8'h04;
   localparam logic [7:0] ANALOG_CONTROL_OFF = 8'h08;
   localparam logic [7:0] CUR_ONE_CODE_OFF = 8'h0c;
   localparam logic [7:0] CUR_TWO_CODE_OFF = 8'h10;
   localparam logic [7:0] OFFSET_TRIM_OFF = 8'h14;
   localparam logic [7:0] GPIO_LEVEL_OFF = 8'h18;
   localparam logic [7:0] GPIO_WAY_OFF = 8'h1c;
   localparam int ADDR_W = 8;
   // field positions in config_main
   localparam int SPEED_BIT = 4;
   localparam int VREF_EN_BIT = 3;
   localparam int VREF_LEVEL_BIT = 2;
   localparam int BUF_EN_BIT = 1;
   localparam int BIT_ORDER_BIT = 0;
   localparam int ID_LSB = 5;
   // field positions in analog_control, plus the offset trim sign bit
   localparam int BURNOUT_BIT = 7;
   localparam int RANGE_TWO_LSB = 5;
   localparam int RANGE_ONE_LSB = 3;
   localparam int GAIN_LSB = 0;
   localparam int SIGN_BIT = 7;
   // reset values
   localparam logic [4:0] CONFIG_MAIN_RST = 5'h0e;
   localparam logic [7:0] INPUT_SELECTOR_RST = 8'h01;
   localparam logic [7:0] ANALOG_CONTROL_RST = 8'h00;
   localparam logic [7:0] CUR_CODE_RST = 8'h00;
   localparam logic [7:0] OFFSET_TRIM_RST = 8'h00;
   localparam logic [7:0] GPIO_LEVEL_RST = 8'h00;
   localparam logic [7:0] GPIO_WAY_RST = 8'hff;
   // factory code, value arbitrary
   localparam logic [2:0] FACTORY_CODE = 3'h5;
   // modulator clock dividers
   localparam int MOD_DIV_SLOW = 256;
   localparam int MOD_DIV_FAST = 128;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### verification/adc_config_register_bank_monitor.sv
// checker for the configuration bank outputs
module adc_config_register_bank_monitor (
   input wire logic clock,
   input wire logic nrst,
   input wire logic modClockEn,
   input wire logic [3:0] positiveInputPick,
   input wire logic [3:0] negativeInputPick,
   input wire logic positiveIsCommon,
   input wire logic negativeIsCommon,
   input wire logic positiveIsTemp,
   input wire logic negativeIsTemp,
   input wire logic [1:0] currentSourceOneRange,
   input wire logic [1:0] currentSourceTwoRange,
   input wire logic [7:0] currentSourceOneCode,
   input wire logic [7:0] currentSourceTwoCode,
   input wire logic [2:0] gainSelect,
   input wire logic [7:0] gainFactor
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   AST_MOD_GAP: assert property (modClockEn |=> !modClockEn [*8])
      else $error("modulator pulses too close");
   AST_GAIN: assert property (gainFactor == (8'h01 << gainSelect))
      else $error("gain factor wrong");
   AST_POS_TEMP: assert property (positiveIsTemp == (positiveInputPick == 4'hf))
      else $error("positive temp flag wrong");
   AST_POS_COM: assert property (positiveIsCommon == (positiveInputPick[3] && !positiveIsTemp))
      else $error("positive common flag wrong");
   AST_NEG_TEMP: assert property (negativeIsTemp == (negativeInputPick == 4'hf))
      else $error("negative temp flag wrong");
   AST_NEG_COM: assert property (negativeIsCommon == (negativeInputPick[3] && !negativeIsTemp))
      else $error("negative common flag wrong");
   AST_ONE_OFF: assert property (currentSourceOneRange == 2'h0 |-> currentSourceOneCode == 8'h00)
      else $error("source one not off");
   AST_TWO_OFF: assert property (currentSourceTwoRange == 2'h0 |-> currentSourceTwoCode == 8'h00)
      else $error("source two not off");
   cover property (modClockEn);
   cover property (positiveIsTemp && negativeIsTemp);
   cover property (currentSourceTwoRange == 2'h3);
endmodule // adc_config_register_bank_monitor

bind adc_config_register_bank adc_config_register_bank_monitor mon (.clock, .nrst, .modClockEn,
   .positiveInputPick, .negativeInputPick, .positiveIsCommon, .negativeIsCommon, .positiveIsTemp,
   .negativeIsTemp, .currentSourceOneRange, .currentSourceTwoRange, .currentSourceOneCode,
   .currentSourceTwoCode, .gainSelect, .gainFactor);

// ### verification/testbench.sv
// self-checking bench for the configuration bank
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import adc_cfg_pkg::*;
   logic clock, nrst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr, gpioIn, gpioOut, gpioOe;
   logic [31:0] wdata, rdata, v;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic vrefEnable, internalVrefLevel, bufferEnable, lsbFirstOut, burnoutSourceOn, offsetNegative, modClockEn;
   logic positiveIsCommon, negativeIsTemp;
   logic [3:0] positiveInputPick;
   logic [1:0] currentSourceOneRange, currentSourceTwoRange;
   logic [7:0] currentSourceOneCode, currentSourceTwoCode, gainFactor;
   logic [6:0] offsetMagnitude;
   int err_total, n_tests, p, i;
   adc_config_register_bank dut (.clock(clock), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .modClockEn(modClockEn),
      .vrefEnable(vrefEnable), .internalVrefLevel(internalVrefLevel), .bufferEnable(bufferEnable),
      .lsbFirstOut(lsbFirstOut), .positiveInputPick(positiveInputPick), .negativeInputPick(),
      .positiveIsCommon(positiveIsCommon), .negativeIsCommon(), .positiveIsTemp(),
      .negativeIsTemp(negativeIsTemp), .burnoutSourceOn(burnoutSourceOn),
      .currentSourceOneRange(currentSourceOneRange), .currentSourceTwoRange(currentSourceTwoRange),
      .currentSourceOneCode(currentSourceOneCode), .currentSourceTwoCode(currentSourceTwoCode),
      .gainSelect(), .gainFactor(gainFactor), .offsetNegative(offsetNegative),
      .offsetMagnitude(offsetMagnitude), .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe));
   initial begin
      clock = 0;
      forever #4 clock = ~clock;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      r = 2'bxx;
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
         if (bvalid) begin
            r = bresp; bready <= 0;
            break;
         end
      end
      @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      r = 2'bxx; v = 'x;
      araddr <= a; arvalid <= 1; rready <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 0;
         if (rvalid) begin
            r = rresp; v = rdata; rready <= 0;
            break;
         end
      end
      @(posedge clock);
   endtask
   task automatic period();
      for (p = 0; p < 600 && modClockEn !== 1'b1; p++) @(negedge clock);
      @(negedge clock);
      for (p = 1; p < 600 && modClockEn !== 1'b1; p++) @(negedge clock);
      @(posedge clock);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      end_of_test();
   end
   initial begin
      nrst = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
      awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hf; gpioIn = 8'h3c; err_total = 0; n_tests = 0;
      repeat (8) @(posedge clock);
      nrst <= 1;
      @(posedge clock);
      rd(8'h00); chk("config reset", 32'hae, v);
      chk("oe reset", 8'h00, gpioOe);
      rd(8'h1c); chk("way reset", 32'hff, v);
      rd(8'h04); chk("selector reset", 32'h01, v);
      wr(8'h00, 32'hff); rd(8'h00); chk("factory kept", 32'hbf, v);
      chk("cfg on", 4'hf, {vrefEnable, internalVrefLevel, bufferEnable, lsbFirstOut});
      period(); chk("slow period", 256, p);
      wr(8'h00, 32'h00); chk("cfg off", 4'h0, {vrefEnable, internalVrefLevel, bufferEnable, lsbFirstOut});
      period(); chk("fast period", 128, p);
      for (i = 0; i < 16; i++) begin
         wr(8'h04, {24'h0, i[3:0], i[3:0]}); chk("pick", i, positiveInputPick);
         chk("common", i[3] && i != 15, positiveIsCommon);
         chk("temp", i == 15, negativeIsTemp);
      end
      wr(8'h0c, 32'h5a); wr(8'h10, 32'hc3); chk("codes off", 16'h0, {currentSourceOneCode, currentSourceTwoCode});
      for (i = 0; i < 8; i++) begin
         wr(8'h08, 32'he8 | i); chk("gain", 8'h01 << i, gainFactor);
      end
      chk("ranges", 4'hd, {currentSourceTwoRange, currentSourceOneRange});
      chk("codes", 16'h5ac3, {currentSourceOneCode, currentSourceTwoCode});
      chk("burnout on", 1, burnoutSourceOn);
      wr(8'h08, 32'h00); chk("burnout off", 0, burnoutSourceOn);
      wr(8'h14, 32'h85); chk("offset", 8'h85, {offsetNegative, offsetMagnitude});
      wr(8'h1c, 32'h0f); chk("oe", 8'hf0, gpioOe);
      wr(8'h18, 32'ha5); chk("gpio out", 8'ha5, gpioOut);
      rd(8'h18); chk("gpio read", 32'hac, v);
      wr(8'h20, 32'h11); chk("bad write resp", RESP_SLVERR, r);
      rd(8'h20); chk("bad read resp", RESP_SLVERR, r);
      chk("bad read data", 32'h0, v);
      end_of_test();
   end
endmodule // testbench
